// *** rtl/mts_pkg.sv ***
// shared constants and carriers for the table readout and port counters
package mts_pkg;
  localparam int ENTRY_W   = 72;
  localparam int STORE_W   = 60;
  localparam int IDX_W     = 10;
  localparam int TBL_DEPTH = 1024;
  localparam int CNT_AW    = 8;
  localparam int CNT_DEPTH = 256;
  localparam int LEN_W     = 11;
  localparam logic [IDX_W-1:0] IDX_LAST  = 10'h3FF;
  localparam logic [IDX_W-1:0] CNT_LIMIT = 10'h0A0;

  // host register indices
  localparam logic [7:0] REG_CTRL       = 8'h6E;
  localparam logic [7:0] REG_ADDR_LO    = 8'h6F;
  localparam logic [7:0] REG_DATA_FIRST = 8'h70;
  localparam logic [7:0] REG_DATA_LAST  = 8'h78;
  localparam int         CTRL_SEL_LSB   = 2;
  localparam logic [2:0] SEL_TBL_READ   = 3'h6;
  localparam logic [2:0] SEL_CNT_READ   = 3'h7;

  // entry and counter word layout
  localparam int         BIT_EMPTY     = 71;
  localparam int         BIT_NOT_READY = 55;
  localparam logic       EMPTY_RESET   = 1'b1;
  localparam logic [9:0] COUNT_RESET   = 10'h000;
  localparam int         BIT_OVF       = 31;
  localparam int         BIT_VALID     = 30;
  localparam int         CNT_VAL_W     = 30;
  localparam logic [31:0] CNT_CLEARED  = 32'h4000_0000;

  // counter offsets within a port block
  localparam logic [4:0] OFS_RX_LO_OCT     = 5'h00;
  localparam logic [4:0] OFS_RX_HI_OCT     = 5'h01;
  localparam logic [4:0] OFS_RX_SHORT_GOOD = 5'h02;
  localparam logic [4:0] OFS_RX_SHORT_BAD  = 5'h03;
  localparam logic [4:0] OFS_RX_LONG_GOOD  = 5'h04;
  localparam logic [4:0] OFS_RX_LONG_ERR   = 5'h05;
  localparam logic [4:0] OFS_RX_SYMBOL     = 5'h06;
  localparam logic [4:0] OFS_RX_CRC        = 5'h07;
  localparam logic [4:0] OFS_RX_FRACT      = 5'h08;
  localparam logic [4:0] OFS_RX_CTRL       = 5'h09;
  localparam logic [4:0] OFS_RX_PAUSE      = 5'h0A;
  localparam logic [4:0] OFS_RX_BCAST      = 5'h0B;
  localparam logic [4:0] OFS_RX_MCAST      = 5'h0C;
  localparam logic [4:0] OFS_RX_UCAST      = 5'h0D;
  localparam logic [4:0] OFS_RX_LEN_MIN    = 5'h0E;
  localparam logic [4:0] OFS_RX_LEN_2      = 5'h0F;
  localparam logic [4:0] OFS_RX_LEN_3      = 5'h10;
  localparam logic [4:0] OFS_RX_LEN_4      = 5'h11;
  localparam logic [4:0] OFS_RX_LEN_5      = 5'h12;
  localparam logic [4:0] OFS_RX_LEN_6      = 5'h13;
  localparam logic [4:0] OFS_TX_LO_OCT     = 5'h14;
  localparam logic [4:0] OFS_TX_HI_OCT     = 5'h15;
  localparam logic [4:0] OFS_TX_LATE_COL   = 5'h16;
  localparam logic [4:0] OFS_TX_PAUSE      = 5'h17;
  localparam logic [4:0] OFS_TX_BCAST      = 5'h18;
  localparam logic [4:0] OFS_TX_MCAST      = 5'h19;
  localparam logic [4:0] OFS_TX_UCAST      = 5'h1A;
  localparam logic [4:0] OFS_TX_DEFER      = 5'h1B;
  localparam logic [4:0] OFS_TX_COLL_ALL   = 5'h1C;
  localparam logic [4:0] OFS_TX_ABANDON    = 5'h1D;
  localparam logic [4:0] OFS_TX_ONE_RETRY  = 5'h1E;
  localparam logic [4:0] OFS_TX_MANY_RETRY = 5'h1F;

  // frame length limits in bytes
  localparam logic [LEN_W-1:0] LEN_MIN      = 11'h040;
  localparam logic [LEN_W-1:0] LEN_B2_TOP   = 11'h07F;
  localparam logic [LEN_W-1:0] LEN_B3_TOP   = 11'h0FF;
  localparam logic [LEN_W-1:0] LEN_B4_TOP   = 11'h1FF;
  localparam logic [LEN_W-1:0] LEN_B5_TOP   = 11'h3FF;
  localparam logic [LEN_W-1:0] LEN_MAX_STD  = 11'h5F2;
  localparam logic [LEN_W-1:0] LEN_MAX_LONG = 11'h600;
  localparam logic [LEN_W-1:0] LEN_JABBER   = 11'h77C;

  typedef enum logic [2:0] {
    ST_INIT, ST_IDLE, ST_TBL_RD, ST_TBL_CAP,
    ST_CNT_RD, ST_CNT_CAP, ST_UPD_RD, ST_UPD_WR
  } mts_state_t;

  typedef struct packed {
    logic [1:0]  aging;
    logic [2:0]  src_port;
    logic [6:0]  filtering_identifier;
    logic [47:0] station_addr;
  } mts_entry_t;

  typedef struct packed {
    logic [LEN_W-1:0] len;
    logic             crc_ok;
    logic             fractional;
    logic             symbol_err;
    logic             bcast;
    logic             mcast;
    logic             ctrl_frame;
    logic             pause_match;
    logic             high_prio;
    logic [2:0]       port;
  } mts_rx_rpt_t;

  typedef struct packed {
    logic [LEN_W-1:0] len;
    logic             good;
    logic             high_prio;
    logic             pause;
    logic             bcast;
    logic             mcast;
    logic             late_col;
    logic             deferred;
    logic             excessive;
    logic [4:0]       retries;
    logic [2:0]       port;
  } mts_tx_rpt_t;
endpackage

// *** rtl/mts_ram.sv ***
// simple dual-port memory with registered read data
`timescale 1ns/1ps
module mts_ram #(
  parameter int W  = 60,
  parameter int D  = 1024,
  parameter int AW = 10
) (
  input  logic          clk,
  input  logic          we,
  input  logic [AW-1:0] waddr,
  input  logic [W-1:0]  wdata,
  input  logic          re,
  input  logic [AW-1:0] raddr,
  output logic [W-1:0]  rdata
);
  logic [W-1:0] mem [D];

  // no reset on storage; the owner sweeps it clean after reset
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (re) begin
      rdata <= mem[raddr];
    end
  end
endmodule

// *** rtl/mts_readout.sv ***
// learned-address table readout and per-port statistics counters
`timescale 1ns/1ps
// Operation
// - host cannot modify learned table entries
// - 72-bit entry, top bit empty, resets 1
// - ten-bit occupancy count beside empty flag
// - two aging bits, read only to host
// - three-bit learning port, codes 0 to 4
// - not-ready bit high while entry fetched
// - filtering identifier then 48-bit station address
// - index top bits sit in control low bits
// - nine data registers, most significant byte first
// - low and high priority receive octets
// - short good and short bad frames
// - long good frames and long errored frames
// - bad checksum split whole versus fractional bytes
// - control frames and qualified pause frames
// - good broadcast, group and single frames
// - receive length histogram, six buckets
// - good transmit octets by priority
// - late collisions, pause, transmit cast types
// - deferral, collisions, abandoned, retry counts
// - counter word carries overflow and valid
// - counter cleared when host reads it
module mts_readout
  import mts_pkg::*;
(
  input  logic              clk,
  input  logic              rst,
  input  logic              host_wr,
  input  logic              host_rd,
  input  logic [7:0]        host_addr,
  input  logic [7:0]        host_wdata,
  output logic [7:0]        host_rdata,
  output logic              fetch_busy,
  input  logic              tbl_empty,
  input  logic [9:0]        tbl_count,
  input  logic              learn_we,
  input  logic [IDX_W-1:0]  learn_idx,
  input  mts_entry_t        learn_entry,
  input  logic              long_max_sel,
  input  logic              rx_rpt_valid,
  input  mts_rx_rpt_t       rx_rpt,
  output logic              rx_rpt_ready,
  input  logic              tx_rpt_valid,
  input  mts_tx_rpt_t       tx_rpt,
  output logic              tx_rpt_ready
);
  mts_state_t         state;
  mts_state_t         next_state;
  logic [7:0]         ctrl;
  logic [7:0]         addr_lo;
  logic [ENTRY_W-1:0] shadow;
  logic               occ_empty;
  logic [9:0]         occ_count;
  logic               pend;
  logic               pend_cnt;
  logic [IDX_W-1:0]   pend_idx;
  logic               fetch_cnt;
  logic [IDX_W-1:0]   fetch_idx;
  logic [IDX_W-1:0]   init_idx;
  logic [31:0]        upd_mask;
  logic [LEN_W-1:0]   upd_len;
  logic [4:0]         upd_retries;
  logic [2:0]         upd_port;
  logic [4:0]         upd_ofs;
  mts_entry_t         tbl_rdata;
  logic [31:0]        cnt_rdata;

  function automatic logic [31:0] rx_mask(input mts_rx_rpt_t r,
                                          input logic        long_sel);
    logic [LEN_W-1:0] lmax;
    logic             bad;
    logic             in_rng;
    logic             good;
    logic [31:0]      m;
    lmax   = long_sel ? LEN_MAX_LONG : LEN_MAX_STD;
    bad    = !r.crc_ok || r.symbol_err || r.fractional;
    in_rng = r.len >= LEN_MIN && r.len <= lmax;
    good   = in_rng && !bad;
    m      = 32'h0000_0000;
    m[r.high_prio ? OFS_RX_HI_OCT : OFS_RX_LO_OCT] = 1'b1;
    m[OFS_RX_SHORT_GOOD] = r.len < LEN_MIN && !bad;
    m[OFS_RX_SHORT_BAD]  = r.len < LEN_MIN && bad;
    m[OFS_RX_LONG_GOOD]  = r.len > lmax && !bad;
    m[OFS_RX_LONG_ERR]   = (r.len > lmax && bad) || r.len > LEN_JABBER;
    m[OFS_RX_SYMBOL]     = in_rng && r.symbol_err;
    m[OFS_RX_CRC]        = in_rng && !r.crc_ok && !r.fractional;
    m[OFS_RX_FRACT]      = in_rng && !r.crc_ok && r.fractional;
    m[OFS_RX_CTRL]       = r.ctrl_frame;
    m[OFS_RX_PAUSE]      = r.ctrl_frame && r.pause_match &&
                           r.len >= LEN_MIN && r.crc_ok;
    m[OFS_RX_BCAST]      = good && r.bcast;
    m[OFS_RX_MCAST]      = good && r.mcast && !r.bcast &&
                           !r.ctrl_frame;
    m[OFS_RX_UCAST]      = good && !r.mcast && !r.bcast;
    m[OFS_RX_LEN_MIN]    = r.len == LEN_MIN;
    m[OFS_RX_LEN_2]      = r.len > LEN_MIN && r.len <= LEN_B2_TOP;
    m[OFS_RX_LEN_3]      = r.len > LEN_B2_TOP && r.len <= LEN_B3_TOP;
    m[OFS_RX_LEN_4]      = r.len > LEN_B3_TOP && r.len <= LEN_B4_TOP;
    m[OFS_RX_LEN_5]      = r.len > LEN_B4_TOP && r.len <= LEN_B5_TOP;
    m[OFS_RX_LEN_6]      = r.len > LEN_B5_TOP && r.len <= lmax;
    return m;
  endfunction

  function automatic logic [31:0] tx_mask(input mts_tx_rpt_t t);
    logic [31:0] m;
    m = 32'h0000_0000;
    m[t.high_prio ? OFS_TX_HI_OCT : OFS_TX_LO_OCT] = t.good;
    m[OFS_TX_LATE_COL]   = t.late_col;
    m[OFS_TX_PAUSE]      = t.pause;
    m[OFS_TX_BCAST]      = t.good && t.bcast;
    m[OFS_TX_MCAST]      = t.good && t.mcast && !t.bcast;
    m[OFS_TX_UCAST]      = t.good && !t.mcast && !t.bcast;
    m[OFS_TX_DEFER]      = t.deferred;
    m[OFS_TX_COLL_ALL]   = t.retries != 5'h00;
    m[OFS_TX_ABANDON]    = t.excessive;
    m[OFS_TX_ONE_RETRY]  = t.good && t.retries == 5'h01;
    m[OFS_TX_MANY_RETRY] = t.good && t.retries > 5'h01;
    return m;
  endfunction

  // host register decode
  wire [2:0] sel       = ctrl[CTRL_SEL_LSB +: 3];
  wire       wr_ctrl   = host_wr && host_addr == REG_CTRL;
  wire       wr_trig   = host_wr && host_addr == REG_ADDR_LO;
  wire       trig_tbl  = wr_trig && sel == SEL_TBL_READ;
  wire       trig_cnt  = wr_trig && sel == SEL_CNT_READ;
  wire       trig      = trig_tbl || trig_cnt;
  wire [IDX_W-1:0] trig_idx = {ctrl[1:0], host_wdata};
  wire       rd_data   = host_addr >= REG_DATA_FIRST &&
                         host_addr <= REG_DATA_LAST;
  // byte 0x70 is the top byte of the entry
  wire [3:0] byte_sel  = 4'(REG_DATA_LAST - host_addr);
  wire [ENTRY_W-1:0] shifted = shadow >> {byte_sel, 3'b000};
  wire [7:0] next_rdata = !host_rd            ? host_rdata :
                          host_addr == REG_CTRL    ? ctrl :
                          host_addr == REG_ADDR_LO ? addr_lo :
                          rd_data             ? shifted[7:0] : 8'h00;

  // report intake, a pending trigger is served first
  assign rx_rpt_ready = state == ST_IDLE && !pend;
  assign tx_rpt_ready = rx_rpt_ready && !rx_rpt_valid;
  wire   rx_take      = rx_rpt_valid && rx_rpt_ready;
  wire   tx_take      = tx_rpt_valid && tx_rpt_ready;
  wire   launch       = state == ST_IDLE && pend;
  assign fetch_busy   = pend || state == ST_TBL_RD ||
                        state == ST_TBL_CAP || state == ST_CNT_RD ||
                        state == ST_CNT_CAP;

  // counter update arithmetic
  wire upd_hit  = upd_mask[upd_ofs];
  wire upd_last = upd_ofs == 5'h1F;
  wire is_oct   = upd_ofs == OFS_RX_LO_OCT || upd_ofs == OFS_RX_HI_OCT ||
                  upd_ofs == OFS_TX_LO_OCT || upd_ofs == OFS_TX_HI_OCT;
  wire [LEN_W-1:0] upd_amt = is_oct ? upd_len :
                             upd_ofs == OFS_TX_COLL_ALL ?
                             {6'h00, upd_retries} : 11'h001;
  wire [30:0] upd_sum  = {1'b0, cnt_rdata[CNT_VAL_W-1:0]} +
                         {20'h00000, upd_amt};
  // overflow stays set until the host read clears the word
  wire [31:0] upd_word = {cnt_rdata[BIT_OVF] | upd_sum[CNT_VAL_W], 1'b1,
                          upd_sum[CNT_VAL_W-1:0]};
  wire cnt_in_map = fetch_idx < CNT_LIMIT;

  // memory port selection
  wire in_init = state == ST_INIT;
  wire tbl_we  = in_init || learn_we;
  wire [IDX_W-1:0] tbl_waddr = in_init ? init_idx : learn_idx;
  wire mts_entry_t tbl_wdata = in_init ? '0 : learn_entry;
  wire cnt_we  = state == ST_UPD_WR ||
                 (state == ST_CNT_CAP && cnt_in_map && !pend) ||
                 (in_init && init_idx < IDX_W'(CNT_DEPTH));
  wire [CNT_AW-1:0] upd_addr  = {upd_port, upd_ofs};
  wire [CNT_AW-1:0] cnt_waddr = in_init ? init_idx[CNT_AW-1:0] :
                                state == ST_UPD_WR ? upd_addr :
                                fetch_idx[CNT_AW-1:0];
  wire [31:0] cnt_wdata = state == ST_UPD_WR ? upd_word :
                          CNT_CLEARED;
  wire cnt_re = state == ST_CNT_RD || state == ST_UPD_RD;
  wire [CNT_AW-1:0] cnt_raddr = state == ST_CNT_RD ?
                                fetch_idx[CNT_AW-1:0] : upd_addr;

  mts_ram #(.W(STORE_W), .D(TBL_DEPTH), .AW(IDX_W)) u_tbl (
    .clk   (clk),
    .we    (tbl_we),
    .waddr (tbl_waddr),
    .wdata (tbl_wdata),
    .re    (state == ST_TBL_RD),
    .raddr (fetch_idx),
    .rdata (tbl_rdata)
  );

  mts_ram #(.W(32), .D(CNT_DEPTH), .AW(CNT_AW)) u_cnt (
    .clk   (clk),
    .we    (cnt_we),
    .waddr (cnt_waddr),
    .wdata (cnt_wdata),
    .re    (cnt_re),
    .raddr (cnt_raddr),
    .rdata (cnt_rdata)
  );

  // fetched entry image, loaded whole so the bytes agree
  wire [ENTRY_W-1:0] tbl_image = {occ_empty, occ_count,
                                  tbl_rdata.aging, tbl_rdata.src_port,
                                  1'b0, tbl_rdata.filtering_identifier,
                                  tbl_rdata.station_addr};
  wire [31:0] cnt_image = cnt_in_map ? cnt_rdata : CNT_CLEARED;

  always_comb begin
    next_state = state;
    case (state)
      ST_INIT: begin
        if (init_idx == IDX_LAST) begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (pend) begin
          next_state = pend_cnt ? ST_CNT_RD : ST_TBL_RD;
        end else if (rx_take || tx_take) begin
          next_state = ST_UPD_RD;
        end
      end
      ST_TBL_RD:  next_state = ST_TBL_CAP;
      ST_TBL_CAP: next_state = ST_IDLE;
      ST_CNT_RD:  next_state = ST_CNT_CAP;
      ST_CNT_CAP: next_state = ST_IDLE;
      ST_UPD_RD: begin
        if (upd_hit) begin
          next_state = ST_UPD_WR;
        end else if (upd_last) begin
          next_state = ST_IDLE;
        end
      end
      ST_UPD_WR:  next_state = upd_last ? ST_IDLE : ST_UPD_RD;
      default:    next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state      <= ST_INIT;
      ctrl       <= 8'h00;
      addr_lo    <= 8'h00;
      host_rdata <= 8'h00;
      occ_empty  <= EMPTY_RESET;
      occ_count  <= COUNT_RESET;
      init_idx   <= 10'h000;
    end else begin
      state      <= next_state;
      host_rdata <= next_rdata;
      occ_empty  <= tbl_empty;
      occ_count  <= tbl_count;
      init_idx   <= in_init ? init_idx + 10'h001 : init_idx;
      if (wr_ctrl) begin
        ctrl <= host_wdata;
      end
      if (wr_trig) begin
        addr_lo <= host_wdata;
      end
    end
  end

  // a trigger that lands during a fetch is queued, not lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend      <= 1'b0;
      pend_cnt  <= 1'b0;
      pend_idx  <= 10'h000;
      fetch_cnt <= 1'b0;
      fetch_idx <= 10'h000;
    end else begin
      if (trig) begin
        pend     <= 1'b1;
        pend_cnt <= trig_cnt;
        pend_idx <= trig_idx;
      end else if (launch) begin
        pend <= 1'b0;
      end
      if (launch) begin
        fetch_cnt <= pend_cnt;
        fetch_idx <= pend_idx;
      end
    end
  end

  // occupancy bytes refresh at table trigger; stale capture skipped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shadow <= {EMPTY_RESET, {(ENTRY_W-1){1'b0}}};
    end else begin
      if (state == ST_TBL_CAP && !pend) begin
        shadow <= tbl_image;
      end
      if (state == ST_CNT_CAP && !pend && fetch_cnt) begin
        shadow <= {40'h00_0000_0000, cnt_image};
      end
      if (trig_tbl) begin
        shadow[BIT_EMPTY:BIT_NOT_READY] <= {occ_empty, occ_count, 6'h01};
      end
      if (trig_cnt) begin
        shadow[ENTRY_W-1:BIT_VALID] <= '0;
      end
    end
  end

  // one report at a time; walks all 32 offsets of its port
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      upd_mask    <= 32'h0000_0000;
      upd_len     <= 11'h000;
      upd_retries <= 5'h00;
      upd_port    <= 3'h0;
      upd_ofs     <= 5'h00;
    end else begin
      if (rx_take) begin
        upd_mask    <= rx_mask(rx_rpt, long_max_sel);
        upd_len     <= rx_rpt.len;
        upd_retries <= 5'h00;
        upd_port    <= rx_rpt.port;
        upd_ofs     <= 5'h00;
      end else if (tx_take) begin
        upd_mask    <= tx_mask(tx_rpt);
        upd_len     <= tx_rpt.len;
        upd_retries <= tx_rpt.retries;
        upd_port    <= tx_rpt.port;
        upd_ofs     <= 5'h00;
      end else if ((state == ST_UPD_RD && !upd_hit) ||
                   state == ST_UPD_WR) begin
        upd_ofs <= upd_ofs + 5'h01;
      end
    end
  end
endmodule

// *** tb/mts_readout_asserts.sv ***
// port checks for the table readout and counter block
`timescale 1ns/1ps
module mts_readout_chk
  import mts_pkg::*;
(
  input logic       clk,
  input logic       rst,
  input logic       host_wr,
  input logic       host_rd,
  input logic [7:0] host_addr,
  input logic [7:0] host_wdata,
  input logic [7:0] host_rdata,
  input logic       fetch_busy,
  input logic       rx_rpt_valid,
  input logic       rx_rpt_ready,
  input logic       tx_rpt_valid,
  input logic       tx_rpt_ready
);
  logic [2:0]  sel;
  logic [1:0]  kind;
  logic [10:0] bcnt;
  wire trig = host_wr && host_addr == REG_ADDR_LO;
  wire ok   = (sel == SEL_TBL_READ) || (sel == SEL_CNT_READ);
  wire r72  = host_rd && host_addr == 8'h72;
  wire r75  = host_rd && host_addr == 8'h75;
  wire take = (rx_rpt_valid && rx_rpt_ready) || (tx_rpt_valid && tx_rpt_ready);
  // kind remembers what the last accepted trigger fetched
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel <= 3'h0;
      kind <= 2'h0;
      bcnt <= 11'h000;
    end else begin
      if (host_wr && host_addr == REG_CTRL) sel <= host_wdata[4:2];
      if (trig && ok) kind <= {sel == SEL_CNT_READ, sel == SEL_TBL_READ};
      bcnt <= fetch_busy ? bcnt + 11'h001 : 11'h000;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_trig;
    trig && ok |=> fetch_busy;
  endproperty
  a_trig: assert property (p_trig) else $error("no fetch after trigger");
  // bound allows a trigger queued behind the start-up sweep
  property p_bound;
    bcnt < 11'h44C;
  endproperty
  a_bound: assert property (p_bound) else $error("fetch never ends");
  property p_nrh;
    r72 && fetch_busy && kind == 2'h1 |=> host_rdata[7];
  endproperty
  a_nrh: assert property (p_nrh) else $error("ready shown early");
  property p_nrl;
    r72 && !fetch_busy && kind == 2'h1 |=> !host_rdata[7];
  endproperty
  a_nrl: assert property (p_nrl) else $error("not-ready stuck");
  property p_cv;
    r75 && !fetch_busy && kind == 2'h2 |=> host_rdata[6];
  endproperty
  a_cv: assert property (p_cv) else $error("counter word not valid");
  property p_off;
    host_rd && (host_addr < REG_CTRL || host_addr > REG_DATA_LAST)
      |=> host_rdata == 8'h00;
  endproperty
  a_off: assert property (p_off) else $error("unmapped read nonzero");
  property p_hold;
    !host_rd |=> $stable(host_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_busy;
    fetch_busy |-> !rx_rpt_ready && !tx_rpt_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("report taken mid fetch");
  property p_upd;
    take |=> (!rx_rpt_ready && !tx_rpt_ready) [*8]
      ##[24:80] (rx_rpt_ready || tx_rpt_ready);
  endproperty
  a_upd: assert property (p_upd) else $error("update length wrong");
endmodule
bind mts_readout mts_readout_chk u_chk (.clk(clk), .rst(rst),
  .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
  .host_wdata(host_wdata), .host_rdata(host_rdata),
  .fetch_busy(fetch_busy), .rx_rpt_valid(rx_rpt_valid),
  .rx_rpt_ready(rx_rpt_ready), .tx_rpt_valid(tx_rpt_valid),
  .tx_rpt_ready(tx_rpt_ready));

// *** tb/mts_host.sv ***
// host model on the management register port
`timescale 1ns/1ps
module mts_host
  import mts_pkg::*;
(
  input  logic       clk,
  input  logic [7:0] host_rdata,
  output logic       host_wr    = 1'b0,
  output logic       host_rd    = 1'b0,
  output logic [7:0] host_addr  = 8'hFF,
  output logic [7:0] host_wdata = 8'h00
);
  // released lines show the inverse so stale values never look valid
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk);
    #1;
    host_wr = w;
    host_rd = !w;
    host_addr = a;
    host_wdata = d;
    @(posedge clk);
    #1;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = ~a;
    host_wdata = ~d;
    q = host_rdata;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic collect(logic [2:0] sel, output logic [71:0] img);
    int n;
    int tries;
    logic [7:0] b;
    n = 0;
    tries = 0;
    img = '0;
    while (n < 9) begin
      acc(1'b0, REG_DATA_FIRST + 8'(n), 8'h00, b);
      img[71-8*n -: 8] = b;
      if (tries < 40 && ((sel == SEL_TBL_READ && n == 2 && b[7]) ||
          (sel == SEL_CNT_READ && n == 5 && !b[6]))) begin
        tries++;
      end else begin
        n++;
      end
    end
  endtask
  task automatic fetch(logic [2:0] sel, logic [9:0] idx,
                       output logic [71:0] img);
    wr(REG_CTRL, {3'h0, sel, idx[9:8]});
    wr(REG_ADDR_LO, idx[7:0]);
    collect(sel, img);
  endtask
endmodule

// *** tb/test_mts_readout.sv ***
// self-checking bench for the table readout and port counters
`timescale 1ns/1ps
module test_mts_readout
  import mts_pkg::*;
;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic             host_wr, host_rd, fetch_busy;
  logic [7:0]       host_addr, host_wdata, host_rdata;
  logic             tbl_empty = EMPTY_RESET;
  logic [9:0]       tbl_count = COUNT_RESET;
  logic             learn_we = 1'b0;
  logic [IDX_W-1:0] learn_idx = 10'h000;
  mts_entry_t       learn_entry = '0;
  logic             long_max_sel = 1'b0;
  logic             rx_rpt_valid = 1'b0;
  mts_rx_rpt_t      rx_rpt = '0;
  logic             tx_rpt_valid = 1'b0;
  mts_tx_rpt_t      tx_rpt = '0;
  logic             rx_rpt_ready, tx_rpt_ready;
  int               fail_count = 0;
  int               num_checks = 0;
  logic [7:0]  ix [19] = '{8'h00, 8'h00, 8'h0B, 8'h0E, 8'h35, 8'h39, 8'h3B,
                           8'h3C, 8'h3F, 8'h80, 8'h88, 8'h87, 8'h90, 8'hA0,
                           8'h43, 8'h44, 8'h49, 8'h4A, 8'h53};
  logic [29:0] ev [19] = '{30'h40, 30'h0, 30'h1, 30'h1, 30'h64, 30'h1, 30'h1,
                           30'h3, 30'h1, 30'hC8, 30'h1, 30'h0, 30'h1, 30'h0,
                           30'h1, 30'h1, 30'h2, 30'h2, 30'h1};
  mts_readout dut (.clk(clk), .rst(rst), .host_wr(host_wr),
    .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .fetch_busy(fetch_busy),
    .tbl_empty(tbl_empty), .tbl_count(tbl_count), .learn_we(learn_we),
    .learn_idx(learn_idx), .learn_entry(learn_entry),
    .long_max_sel(long_max_sel), .rx_rpt_valid(rx_rpt_valid),
    .rx_rpt(rx_rpt), .rx_rpt_ready(rx_rpt_ready),
    .tx_rpt_valid(tx_rpt_valid), .tx_rpt(tx_rpt),
    .tx_rpt_ready(tx_rpt_ready));
  mts_host host (.clk(clk), .host_rdata(host_rdata), .host_wr(host_wr),
    .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata));
  always #25 clk = ~clk;
  task automatic chk(string w, logic [71:0] s, logic [71:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ready comes back only once the start-up sweep, a fetch or an update is over
  task automatic idle();
    int k;
    k = 0;
    while (rx_rpt_ready !== 1'b1 && k < 3000) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("idle", rx_rpt_ready, 1'b1);
  endtask
  task automatic learn(logic [9:0] i, mts_entry_t e);
    @(posedge clk);
    #1;
    learn_we = 1'b1;
    learn_idx = i;
    learn_entry = e;
    @(posedge clk);
    #1;
    learn_we = 1'b0;
  endtask
  task automatic send(logic rv, mts_rx_rpt_t r, logic tv, mts_tx_rpt_t t);
    logic rg;
    logic tg;
    @(posedge clk);
    #1;
    rx_rpt_valid = rv;
    rx_rpt = r;
    tx_rpt_valid = tv;
    tx_rpt = t;
    while (rx_rpt_valid || tx_rpt_valid) begin
      @(posedge clk);
      rg = rx_rpt_valid && rx_rpt_ready;
      tg = tx_rpt_valid && tx_rpt_ready;
      #1;
      if (rg) begin
        rx_rpt_valid = 1'b0;
        rx_rpt = ~r;
      end
      if (tg) begin
        tx_rpt_valid = 1'b0;
        tx_rpt = ~t;
      end
    end
  endtask
  task automatic t_empty();
    logic [71:0] img;
    idle();
    host.fetch(SEL_TBL_READ, 10'h000, img);
    chk("empty", img, {EMPTY_RESET, COUNT_RESET, 61'h0});
  endtask
  task automatic t_entry();
    logic [71:0] img;
    logic [71:0] again;
    mts_entry_t e;
    logic [7:0] q;
    e = '{2'h2, 3'h4, 7'h55, 48'hA1B2C3D4E5F6};
    tbl_empty = 1'b0;
    tbl_count = 10'h3FF;
    learn(10'h101, e);
    learn(IDX_LAST, ~e);
    host.fetch(SEL_TBL_READ, 10'h101, img);
    chk("entry", img, {11'h3FF, e[59:55], 1'b0, e[54:0]});
    for (int n = 0; n < 9; n++) begin
      host.wr(REG_DATA_FIRST + 8'(n), 8'hFF);
    end
    host.collect(SEL_TBL_READ, again);
    chk("hold", again, img);
    host.acc(1'b0, 8'h79, 8'h00, q);
    chk("unmapped", q, 72'h0);
    tbl_count = 10'h001;
    e = ~e;
    host.wr(REG_CTRL, {3'h0, SEL_TBL_READ, IDX_LAST[9:8]});
    host.wr(REG_ADDR_LO, IDX_LAST[7:0]);
    host.acc(1'b0, REG_DATA_FIRST + 8'h02, 8'h00, q);
    chk("busy", q[7], 1'b1);
    host.collect(SEL_TBL_READ, img);
    chk("last", img, {11'h001, e[59:55], 1'b0, e[54:0]});
  endtask
  task automatic t_stats();
    logic [71:0] img;
    mts_rx_rpt_t a;
    mts_rx_rpt_t c;
    mts_rx_rpt_t d;
    mts_rx_rpt_t f;
    mts_tx_rpt_t b;
    a = '{len: 11'h040, crc_ok: 1'b1, bcast: 1'b1, default: '0};
    b = '{len: 11'h064, good: 1'b1, high_prio: 1'b1, mcast: 1'b1,
          deferred: 1'b1, retries: 5'h03, port: 3'h1, default: '0};
    c = '{len: 11'h0C8, fractional: 1'b1, port: 3'h4, default: '0};
    d = '{len: 11'h5FA, crc_ok: 1'b1, ctrl_frame: 1'b1, pause_match: 1'b1,
          port: 3'h2, default: '0};
    f = '{len: 11'h020, port: 3'h2, default: '0};
    send(1'b1, a, 1'b1, b);
    send(1'b1, c, 1'b0, b);
    send(1'b1, d, 1'b0, b);
    long_max_sel = 1'b1;
    send(1'b1, d, 1'b0, b);
    send(1'b1, f, 1'b0, b);
    // the second read of offset 0 sees the cleared word
    for (int i = 0; i < 14; i++) begin
      host.fetch(SEL_CNT_READ, {2'h0, ix[i]}, img);
      chk("counter", img, {40'h0, CNT_CLEARED | {2'h0, ev[i]}});
    end
    for (int i = 14; i < 19; i++) begin
      host.fetch(SEL_CNT_READ, {2'h0, ix[i]}, img);
      chk("counter", img, {40'h0, CNT_CLEARED | {2'h0, ev[i]}});
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    t_empty();
    t_entry();
    t_stats();
    conclude();
  end
  initial begin
    #1000000;
    fail_count++;
    conclude();
  end
endmodule
